// ==== hdl/secure_control_register.sv ====
/*
 Secure control register, its acknowledge copy, the implementation defined id word,
 and the fetch-guard fault decision that these bits steer.
 Assumes register requests and side-logic status are synchronous to clock_i, and that
 the queue and translation engines report idle when they have quiesced.
*/
`timescale 1ns/1ps
module secure_control_register #(
	parameter logic [31:0] IMPL_ID = secure_ctrl_pkg::IMPL_ID_DEFAULT
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire secure_ctrl_pkg::reg_req_t req_i,
	input wire logic secure_state_present_i,
	input wire logic [1:0] secure_stall_model_i,
	input wire logic vmid_wildcard_support_i,
	input wire logic cmdq_idle_i,
	input wire logic evtq_idle_i,
	input wire logic xlat_idle_i,
	input wire secure_ctrl_pkg::txn_t txn_i,
	output logic [31:0] rd_data_o,
	output logic rd_valid_o,
	output logic translation_enable_o,
	output logic command_queue_enable_o,
	output logic event_queue_enable_o,
	output logic fetch_guard_o,
	output logic nonsecure_stall_disable_o,
	output logic [1:0] nonsecure_stall_model_o,
	output logic [15:0] vmid_ignore_mask_o,
	output secure_ctrl_pkg::fault_t fault_o
);

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	logic [9:0] control;
	logic [9:0] ack;
	logic [31:0] impl_mask;
	logic access_ok;
	logic ctrl_write;
	logic [9:0] next_control;
	logic [1:0] next_stall_model;
	logic [2:0] vmw_ctrl;

	assign access_ok = req_i.valid && req_i.secure && secure_state_present_i;
	assign ctrl_write = access_ok && req_i.write && (req_i.addr == secure_ctrl_pkg::OFS_CONTROL);

	// stall disable reserved unless model is 00
	always_comb
	begin
		impl_mask = secure_ctrl_pkg::BASE_MASK;
		if (vmid_wildcard_support_i)
			impl_mask = impl_mask | secure_ctrl_pkg::VMW_MASK;
		if (secure_stall_model_i == secure_ctrl_pkg::STALL_MODEL_BOTH)
			impl_mask = impl_mask | secure_ctrl_pkg::STALL_DIS_MASK;
	end

	assign next_control = req_i.wdata[9:0] & impl_mask[9:0];

	// ----------------------------------------
	// Control register
	// ----------------------------------------
	// reset to zero
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			control <= secure_ctrl_pkg::CONTROL_RESET;
		else if (ctrl_write)
			control <= next_control;
		else
			control <= control & impl_mask[9:0];
	end

	// ----------------------------------------
	// Stall model id
	// ----------------------------------------
	// terminate only when disabled
	always_comb
	begin
		next_stall_model = secure_stall_model_i;
		if (secure_stall_model_i == secure_ctrl_pkg::STALL_MODEL_BOTH
			&& control[secure_ctrl_pkg::BIT_STALL_DIS])
			next_stall_model = secure_ctrl_pkg::STALL_MODEL_TERM;
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			nonsecure_stall_model_o <= secure_ctrl_pkg::STALL_MODEL_BOTH;
		else
			nonsecure_stall_model_o <= next_stall_model;
	end

	// ----------------------------------------
	// Acknowledge copy
	// ----------------------------------------
	// ack follows control after completion
	// each field acked on its own terms
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			ack <= secure_ctrl_pkg::CONTROL_RESET;
		else
		begin
			if (control[secure_ctrl_pkg::BIT_XLAT_EN] || xlat_idle_i)
				ack[secure_ctrl_pkg::BIT_XLAT_EN] <= control[secure_ctrl_pkg::BIT_XLAT_EN];
			if (control[secure_ctrl_pkg::BIT_EVTQ_EN] || evtq_idle_i)
				ack[secure_ctrl_pkg::BIT_EVTQ_EN] <= control[secure_ctrl_pkg::BIT_EVTQ_EN];
			if (control[secure_ctrl_pkg::BIT_CMDQ_EN] || cmdq_idle_i)
				ack[secure_ctrl_pkg::BIT_CMDQ_EN] <= control[secure_ctrl_pkg::BIT_CMDQ_EN];
			ack[secure_ctrl_pkg::BIT_FETCH_GUARD] <= control[secure_ctrl_pkg::BIT_FETCH_GUARD];
			ack[8:6] <= control[8:6];
			// ack only once model id shows it
			if (nonsecure_stall_model_o == next_stall_model)
				ack[secure_ctrl_pkg::BIT_STALL_DIS] <= control[secure_ctrl_pkg::BIT_STALL_DIS];
			ack[1] <= 1'b0;
			ack[4] <= 1'b0;
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	// implementation defined word
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rd_data_o <= 32'h0000_0000;
			rd_valid_o <= 1'b0;
		end
		else
		begin
			rd_valid_o <= req_i.valid && !req_i.write;
			rd_data_o <= 32'h0000_0000;
			if (access_ok && !req_i.write)
			begin
				unique case (req_i.addr)
					secure_ctrl_pkg::OFS_IMPL_ID: rd_data_o <= IMPL_ID;
					secure_ctrl_pkg::OFS_CONTROL: rd_data_o <= {22'h0, control} & impl_mask;
					secure_ctrl_pkg::OFS_ACK: rd_data_o <= {22'h0, ack} & impl_mask;
					default: rd_data_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Steering outputs
	// ----------------------------------------
	// Wildcard decoded from the acknowledged value so invalidations never run ahead of it.
	assign vmw_ctrl = ack[8:6];

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			translation_enable_o <= 1'b0;
			command_queue_enable_o <= 1'b0;
			event_queue_enable_o <= 1'b0;
			fetch_guard_o <= 1'b0;
			nonsecure_stall_disable_o <= 1'b0;
			vmid_ignore_mask_o <= 16'h0000;
		end
		else
		begin
			translation_enable_o <= control[secure_ctrl_pkg::BIT_XLAT_EN];
			command_queue_enable_o <= control[secure_ctrl_pkg::BIT_CMDQ_EN];
			event_queue_enable_o <= control[secure_ctrl_pkg::BIT_EVTQ_EN];
			fetch_guard_o <= control[secure_ctrl_pkg::BIT_FETCH_GUARD];
			nonsecure_stall_disable_o <= control[secure_ctrl_pkg::BIT_STALL_DIS];
			if (vmw_ctrl <= secure_ctrl_pkg::VMW_MAX)
				vmid_ignore_mask_o <= 16'((17'h1 << vmw_ctrl) - 17'h1);
			else
				vmid_ignore_mask_o <= 16'h0000;
		end
	end

	// ----------------------------------------
	// Fetch guard decision
	// ----------------------------------------
	logic guard_hit;

	// translated path relies on TLB invalidation
	assign guard_hit = txn_i.valid && txn_i.secure_stream && txn_i.instr_fetch
		&& txn_i.s1_out_nonsecure && ack[secure_ctrl_pkg::BIT_FETCH_GUARD];

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			fault_o <= '0;
		else
		begin
			fault_o <= '0;
			if (guard_hit)
			begin
				fault_o.fault <= 1'b1;
				if (!ack[secure_ctrl_pkg::BIT_XLAT_EN])
					fault_o.abort <= 1'b1;
				else if (txn_i.stream_bypass)
				begin
					fault_o.abort <= 1'b1;
					fault_o.record_event <= ack[secure_ctrl_pkg::BIT_EVTQ_EN];
				end
				else
				begin
					fault_o.stall <= txn_i.cd_stall;
					fault_o.abort <= !txn_i.cd_stall;
					fault_o.record_event <= ack[secure_ctrl_pkg::BIT_EVTQ_EN];
				end
			end
		end
	end

endmodule // secure_control_register

// ==== hdl/secure_ctrl_pkg.sv ====
/*
 Constants, field layout and carrier types for the secure control register bank.
 Assumes one core clock, an asynchronous active-high reset, and page-zero byte addresses.
*/
package secure_ctrl_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [15:0] OFS_IMPL_ID = 16'h8010;
	localparam logic [15:0] OFS_CONTROL = 16'h8020;
	localparam logic [15:0] OFS_ACK = 16'h8024;

	// ----------------------------------------
	// Control fields
	// ----------------------------------------
	localparam int BIT_XLAT_EN = 0;
	localparam int BIT_EVTQ_EN = 2;
	localparam int BIT_CMDQ_EN = 3;
	localparam int BIT_FETCH_GUARD = 5;
	localparam int BIT_VMW_LO = 6;
	localparam int BIT_STALL_DIS = 9;
	localparam logic [31:0] BASE_MASK = 32'h0000_002d;
	localparam logic [31:0] VMW_MASK = 32'h0000_01c0;
	localparam logic [31:0] STALL_DIS_MASK = 32'h0000_0200;
	localparam logic [9:0] CONTROL_RESET = 10'h000;
	localparam logic [2:0] VMW_MAX = 3'h4;
	localparam logic [1:0] STALL_MODEL_BOTH = 2'h0;
	localparam logic [1:0] STALL_MODEL_TERM = 2'h1;
	// Arbitrary neutral value
	localparam logic [31:0] IMPL_ID_DEFAULT = 32'h0000_0000;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic valid;
		logic write;
		logic secure;
		logic [15:0] addr;
		logic [31:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic valid;
		logic secure_stream;
		logic instr_fetch;
		logic s1_out_nonsecure;
		logic stream_bypass;
		logic cd_stall;
	} txn_t;

	typedef struct packed {
		logic fault;
		logic abort;
		logic stall;
		logic record_event;
	} fault_t;

endpackage

// ==== sim/secure_ctrl_sva.sv ====
/*
 Port checker for the secure control register, bound into the design module.
 Assumes straps stay put around register traffic.
*/
`timescale 1ns/1ps
module secure_ctrl_sva (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire secure_ctrl_pkg::reg_req_t req_i,
	input wire logic secure_state_present_i,
	input wire logic [1:0] secure_stall_model_i,
	input wire secure_ctrl_pkg::txn_t txn_i,
	input wire logic [31:0] rd_data_o,
	input wire logic rd_valid_o,
	input wire logic translation_enable_o,
	input wire logic command_queue_enable_o,
	input wire logic event_queue_enable_o,
	input wire logic fetch_guard_o,
	input wire logic nonsecure_stall_disable_o,
	input wire logic [1:0] nonsecure_stall_model_o,
	input wire secure_ctrl_pkg::fault_t fault_o
);
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic ctl_wr;
	assign ctl_wr = req_i.valid && req_i.write && req_i.secure && secure_state_present_i
		&& req_i.addr == secure_ctrl_pkg::OFS_CONTROL;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);
	chk_read_answer: assert property (req_i.valid && !req_i.write |=> rd_valid_o)
		else $error("read unanswered");
	chk_absent_zero: assert property (rd_valid_o && !$past(secure_state_present_i)
		|-> rd_data_o == 32'h0) else $error("absent bank read nonzero");
	chk_nonsec_zero: assert property (rd_valid_o && !$past(req_i.secure)
		|-> rd_data_o == 32'h0) else $error("non-secure read nonzero");
	chk_reserved_zero: assert property (rd_valid_o
		&& $past(req_i.addr) != secure_ctrl_pkg::OFS_IMPL_ID
		|-> (rd_data_o & 32'hffff_fc12) == 32'h0) else $error("reserved bit set");
	chk_enable_follow: assert property (ctl_wr |-> ##2
		{translation_enable_o, event_queue_enable_o, command_queue_enable_o} ==
		{$past(req_i.wdata[0], 2), $past(req_i.wdata[2], 2), $past(req_i.wdata[3], 2)})
		else $error("enable outputs wrong");
	chk_guard_follow: assert property (ctl_wr |-> ##2
		fetch_guard_o == $past(req_i.wdata[5], 2)) else $error("fetch guard wrong");
	chk_stall_model: assert property (secure_stall_model_i == 2'h0 ##1
		secure_stall_model_i == 2'h0 |-> nonsecure_stall_model_o ==
		{1'b0, nonsecure_stall_disable_o}) else $error("stall model wrong");
	chk_stall_reserved: assert property (secure_stall_model_i != 2'h0 ##1
		$stable(secure_stall_model_i) [*2] |-> !nonsecure_stall_disable_o
		&& nonsecure_stall_model_o == secure_stall_model_i) else $error("stall copy wrong");
	chk_fault_cause: assert property (fault_o.fault |-> $past(txn_i.valid)
		&& $past(txn_i.secure_stream) && $past(txn_i.instr_fetch)
		&& $past(txn_i.s1_out_nonsecure)) else $error("fault without cause");
	chk_fault_kind: assert property (fault_o.fault |-> fault_o.abort != fault_o.stall)
		else $error("fault outcome wrong");
endmodule // secure_ctrl_sva
bind secure_control_register secure_ctrl_sva secure_ctrl_sva_i (
	.clock_i(clock_i), .rst_i(rst_i), .req_i(req_i), .txn_i(txn_i),
	.secure_state_present_i(secure_state_present_i), .secure_stall_model_i(secure_stall_model_i),
	.rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .fault_o(fault_o),
	.translation_enable_o(translation_enable_o), .command_queue_enable_o(command_queue_enable_o),
	.event_queue_enable_o(event_queue_enable_o), .fetch_guard_o(fetch_guard_o),
	.nonsecure_stall_disable_o(nonsecure_stall_disable_o),
	.nonsecure_stall_model_o(nonsecure_stall_model_o)
);

// ==== sim/testbench.sv ====
/*
 Self-checking bench for the secure control register with a small register model.
 Assumes the checker is bound from its own file.
*/
`timescale 1ns/1ps
`define chk(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; $display("Error %0t %h %h", $time, (a), (b)); end end
module testbench;
	logic clock_i, rst_i, pres, wsup, idle, rvalid, xen, cen, een, fg, sd;
	logic [1:0] sm, nsm;
	logic [15:0] vmask;
	logic [31:0] rdata, ctrl, d;
	secure_ctrl_pkg::reg_req_t req;
	secure_ctrl_pkg::txn_t txn;
	secure_ctrl_pkg::fault_t flt;
	int n_fail, compares, seed, i;
	logic [31:0] tc[6] = '{32'h24, 32'h21, 32'h0, 32'h21, 32'h25, 32'h25};
	logic [5:0] tt[6] = '{6'h3c, 6'h3d, 6'h3c, 6'h34, 6'h3c, 6'h3e};
	logic [3:0] te[6] = '{4'hc, 4'ha, 4'h0, 4'h0, 4'hd, 4'hd};
	secure_control_register secure_control_register_i (.clock_i(clock_i), .rst_i(rst_i),
		.req_i(req), .secure_state_present_i(pres), .secure_stall_model_i(sm),
		.vmid_wildcard_support_i(wsup), .cmdq_idle_i(idle), .evtq_idle_i(idle),
		.xlat_idle_i(idle), .txn_i(txn), .rd_data_o(rdata), .rd_valid_o(rvalid),
		.translation_enable_o(xen), .command_queue_enable_o(cen), .event_queue_enable_o(een),
		.fetch_guard_o(fg), .nonsecure_stall_disable_o(sd), .nonsecure_stall_model_o(nsm),
		.vmid_ignore_mask_o(vmask), .fault_o(flt));
	// ----------------------------------------
	// Model and bus tasks
	// ----------------------------------------
	function automatic logic [31:0] mask();
		return 32'h2d | (wsup ? 32'h1c0 : 32'h0) | (sm == 2'h0 ? 32'h200 : 32'h0);
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	task automatic drv(input logic w, input logic s, input logic [15:0] a, input logic [31:0] v);
		req = {1'b1, w, s, a, v};
		@(posedge clock_i);
		req.valid <= 1'b0;
		#1;
	endtask
	task automatic wr(input logic s, input logic [15:0] a, input logic [31:0] v);
		drv(1'b1, s, a, v);
		if (s && pres && a == secure_ctrl_pkg::OFS_CONTROL)
			ctrl = v & mask();
	endtask
	task automatic rd(input logic s, input logic [15:0] a, input logic [31:0] e);
		drv(1'b0, s, a, 32'h0);
		`chk(rvalid, 1'b1)
		`chk(rdata, e)
	endtask
	task automatic results;
		if (n_fail == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		clock_i = 1'b0;
		forever #12.5 clock_i = ~clock_i;
	end
	// Generous bound; the sequence needs well under a thousand cycles
	initial
	begin
		#100000;
		n_fail++;
		results();
	end
	initial
	begin
		seed = 62492;
		rst_i = 1'b1;
		req = '0;
		txn = '0;
		{pres, wsup, idle, sm, ctrl} = {3'h7, 2'h0, 32'h0};
		repeat (6) @(posedge clock_i);
		#1 rst_i = 1'b0;
		`chk({xen, cen, een, fg, sd, vmask}, 21'h0)
		rd(1'b1, secure_ctrl_pkg::OFS_ACK, 32'h0);
		// no stall traffic runs while the stall disable bit is rewritten
		for (i = 0; i < 16; i++)
		begin
			wsup = i[3];
			sm = 2'($random(seed)) & {2{i[0]}};
			cyc(3);
			ctrl = ctrl & mask();
			d = $random(seed);
			d[8:6] = i[2:0];
			wr(1'b1, secure_ctrl_pkg::OFS_CONTROL, d);
			cyc(4);
			rd(1'b1, secure_ctrl_pkg::OFS_CONTROL, ctrl);
			rd(1'b1, secure_ctrl_pkg::OFS_ACK, ctrl);
			`chk({xen, een, cen, fg, sd}, {ctrl[0], ctrl[2], ctrl[3], ctrl[5], ctrl[9]})
			`chk(nsm, sm == 2'h0 ? {1'b0, ctrl[9]} : sm)
			`chk(vmask, ctrl[8:6] <= 3'h4 ? 16'((1 << ctrl[8:6]) - 1) : 16'h0)
		end
		wr(1'b0, secure_ctrl_pkg::OFS_CONTROL, 32'hffff_ffff);
		wr(1'b1, secure_ctrl_pkg::OFS_ACK, 32'hffff_ffff);
		rd(1'b0, secure_ctrl_pkg::OFS_IMPL_ID, 32'h0);
		rd(1'b1, secure_ctrl_pkg::OFS_IMPL_ID, secure_ctrl_pkg::IMPL_ID_DEFAULT);
		rd(1'b1, 16'h8030, 32'h0);
		rd(1'b0, secure_ctrl_pkg::OFS_CONTROL, 32'h0);
		rd(1'b1, secure_ctrl_pkg::OFS_CONTROL, ctrl);
		pres = 1'b0;
		wr(1'b1, secure_ctrl_pkg::OFS_CONTROL, 32'hffff_ffff);
		rd(1'b1, secure_ctrl_pkg::OFS_CONTROL, 32'h0);
		// Second reset restores a known bank after the absent phase
		rst_i = 1'b1;
		cyc(2);
		{rst_i, pres, ctrl} = {2'h1, 32'h0};
		rd(1'b1, secure_ctrl_pkg::OFS_CONTROL, 32'h0);
		// no cached guard copies here; traffic waits until the guard is acknowledged
		foreach (tt[k])
		begin
			wr(1'b1, secure_ctrl_pkg::OFS_CONTROL, tc[k]);
			cyc(4);
			txn = tt[k];
			@(posedge clock_i);
			txn <= '0;
			#1;
			`chk(flt, te[k])
		end
		idle = 1'b0;
		wr(1'b1, secure_ctrl_pkg::OFS_CONTROL, 32'h0);
		cyc(4);
		rd(1'b1, secure_ctrl_pkg::OFS_ACK, 32'h5);
		idle = 1'b1;
		cyc(4);
		rd(1'b1, secure_ctrl_pkg::OFS_ACK, 32'h0);
		results();
	end
endmodule // testbench
